// ==== rtl/spmux_pkg.sv ====
package spmux_pkg;
    // ****************************************************
    // register map: printed offsets are indices, byte = 4x
    // ****************************************************
    localparam logic [7:0]  IDX_STEP2_LOW  = 8'he0;
    localparam logic [7:0]  IDX_STEP2_HIGH = 8'he1;
    localparam logic [7:0]  IDX_STEP3_LOW  = 8'he2;
    localparam logic [11:0] ADDR_STEP2_LOW  = {2'h0, IDX_STEP2_LOW, 2'h0};
    localparam logic [11:0] ADDR_STEP2_HIGH = {2'h0, IDX_STEP2_HIGH, 2'h0};
    localparam logic [11:0] ADDR_STEP3_LOW  = {2'h0, IDX_STEP3_LOW, 2'h0};

    // ****************************************************
    // field positions
    // ****************************************************
    localparam int PD_FIELD_W   = 2;
    localparam int PD_COUNT     = 6;
    localparam int MOD_COUNT    = 3;
    localparam int PREDICT_LSB  = 4;
    localparam int PREDICT_W    = 4;

    // ****************************************************
    // reset values
    // ****************************************************
    localparam logic [7:0] RST_STEP2_LOW  = 8'h07;
    localparam logic [7:0] RST_STEP2_HIGH = 8'hf8;
    localparam logic [7:0] RST_STEP3_LOW  = 8'h24;

    // ****************************************************
    // routing codes and bus answers
    // ****************************************************
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== rtl/spmux_cfg.sv ====
`timescale 1ns/1ps
module spmux_cfg (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // sequencer side
    input  wire logic        step_enter,
    input  wire logic [1:0]  step_index,
    input  wire logic [3:0]  step3_high_routing,
    // photodiode switch matrix
    output logic             route_valid,
    output logic [11:0]      photodiode_route,
    output logic [5:0]       modulator0_photodiodes,
    output logic [5:0]       modulator1_photodiodes,
    output logic [5:0]       modulator2_photodiodes,
    output logic             predict_enable
);
    // ****************************************************
    // registers
    // ****************************************************
    logic [7:0]  step2_routing_low;
    logic [7:0]  step2_routing_high_predict_pattern;
    logic [7:0]  step3_routing_low;
    logic [11:0] aw_addr;
    logic [7:0]  w_byte;
    logic        w_lane0;
    logic        write_do;
    logic [11:0] next_route;
    logic        next_valid;

    // ready low marks a held half; write once both held, none pending
    assign write_do = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    // ****************************************************
    // write channel
    // ****************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_awready <= 1'b1;
            aw_addr       <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
        end else if (write_do) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_wready <= 1'b1;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_byte       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
        end else if (write_do) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= spmux_pkg::RESP_OKAY;
        end else if (write_do) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr[11:2] == spmux_pkg::ADDR_STEP2_LOW[11:2] ||
                aw_addr[11:2] == spmux_pkg::ADDR_STEP2_HIGH[11:2] ||
                aw_addr[11:2] == spmux_pkg::ADDR_STEP3_LOW[11:2]) begin
                s_axi_bresp <= spmux_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= spmux_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ****************************************************
    // configuration bytes
    // ****************************************************
    // byte lanes above lane 0 carry nothing, so only wstrb[0] counts
    always_ff @(posedge clk) begin
        if (srst) begin
            step2_routing_low <= spmux_pkg::RST_STEP2_LOW;
            step2_routing_high_predict_pattern <=
                spmux_pkg::RST_STEP2_HIGH;
            step3_routing_low <= spmux_pkg::RST_STEP3_LOW;
        end else if (write_do && w_lane0) begin
            unique case (aw_addr[11:2])
                spmux_pkg::ADDR_STEP2_LOW[11:2]: begin
                    step2_routing_low <= w_byte;
                end
                spmux_pkg::ADDR_STEP2_HIGH[11:2]: begin
                    step2_routing_high_predict_pattern <= w_byte;
                end
                spmux_pkg::ADDR_STEP3_LOW[11:2]: begin
                    step3_routing_low <= w_byte;
                end
                default: ;
            endcase
        end
    end

    // ****************************************************
    // read channel
    // ****************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= spmux_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rresp   <= spmux_pkg::RESP_OKAY;
            unique case (s_axi_araddr[11:2])
                spmux_pkg::ADDR_STEP2_LOW[11:2]: begin
                    s_axi_rdata <= {24'h000000, step2_routing_low};
                end
                spmux_pkg::ADDR_STEP2_HIGH[11:2]: begin
                    s_axi_rdata <= {24'h000000,
                                    step2_routing_high_predict_pattern};
                end
                spmux_pkg::ADDR_STEP3_LOW[11:2]: begin
                    s_axi_rdata <= {24'h000000, step3_routing_low};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= spmux_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************************
    // step application
    // ****************************************************
    // steps 0 and 1 are routed by neighbouring registers: route_valid low
    always_comb begin
        next_route = 12'h000;
        next_valid = 1'b0;
        unique case (step_index)
            2'h2: begin
                next_route = {step2_routing_high_predict_pattern[3:0],
                              step2_routing_low};
                next_valid = 1'b1;
            end
            2'h3: begin
                next_route = {step3_high_routing, step3_routing_low};
                next_valid = 1'b1;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            route_valid      <= 1'b0;
            photodiode_route <= 12'h000;
            predict_enable   <= 1'b0;
        end else if (step_enter) begin
            route_valid      <= next_valid;
            photodiode_route <= next_route;
            predict_enable   <= step2_routing_high_predict_pattern[
                spmux_pkg::PREDICT_LSB + int'(step_index)];
        end
    end

    // per-modulator photodiode masks, decoded from the same routing
    always_ff @(posedge clk) begin
        if (srst) begin
            modulator0_photodiodes <= 6'h00;
            modulator1_photodiodes <= 6'h00;
            modulator2_photodiodes <= 6'h00;
        end else if (step_enter) begin
            for (int p = 0; p < spmux_pkg::PD_COUNT; p++) begin
                modulator0_photodiodes[p] <= next_route[2*p +: 2] == 2'h1;
                modulator1_photodiodes[p] <= next_route[2*p +: 2] == 2'h2;
                modulator2_photodiodes[p] <= next_route[2*p +: 2] == 2'h3;
            end
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_decode;
        step_enter |=> (modulator0_photodiodes[0] ==
            (photodiode_route[1:0] == 2'h1)) &&
            (modulator2_photodiodes[0] ==
            (photodiode_route[1:0] == 2'h3)) &&
            !(modulator1_photodiodes[0] &&
            photodiode_route[1:0] == spmux_pkg::CODE_NONE);
    endproperty
    a_decode: assert property (p_decode)
        else $error("routing code decoded to wrong modulator");
    property p_reset_vals;
        $fell(srst) |-> step2_routing_low == 8'h07 &&
            step2_routing_high_predict_pattern[3:0] == 4'h8 &&
            step3_routing_low == 8'h24;
    endproperty
    a_reset_vals: assert property (@(posedge clk) p_reset_vals)
        else $error("routing reset value wrong");
    property p_predict_reset;
        $fell(srst) |-> step2_routing_high_predict_pattern[7:4] == 4'hf;
    endproperty
    a_predict_reset: assert property (@(posedge clk) p_predict_reset)
        else $error("predictive flags not all set after reset");
    property p_write_low;
        write_do && w_lane0 &&
            aw_addr[11:2] == spmux_pkg::ADDR_STEP3_LOW[11:2]
            |=> step3_routing_low == $past(w_byte);
    endproperty
    a_write_low: assert property (p_write_low)
        else $error("step-3 low byte not updated");
    property p_write_high;
        write_do && w_lane0 &&
            aw_addr[11:2] == spmux_pkg::ADDR_STEP2_HIGH[11:2]
            |=> step2_routing_high_predict_pattern == $past(w_byte);
    endproperty
    a_write_high: assert property (p_write_high)
        else $error("step-2 high byte not updated");
    property p_readback;
        s_axi_arvalid && s_axi_arready &&
            s_axi_araddr[11:2] == spmux_pkg::ADDR_STEP2_LOW[11:2]
            |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(step2_routing_low)
                && s_axi_rresp == spmux_pkg::RESP_OKAY;
    endproperty
    a_readback: assert property (p_readback)
        else $error("read did not return held byte");
    property p_step_flag;
        step_enter |=> predict_enable == $past(
            step2_routing_high_predict_pattern[4 + int'(step_index)]);
    endproperty
    a_step_flag: assert property (p_step_flag)
        else $error("predictive flag taken from wrong step");
    property p_apply;
        step_enter && step_index == 2'h2 |=> route_valid &&
            photodiode_route[7:0] == $past(step2_routing_low)
            ##1 ($past(step_enter) || $stable(photodiode_route));
    endproperty
    a_apply: assert property (p_apply)
        else $error("step-2 routing not applied or not held");
    property p_bresp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && !s_axi_bvalid |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response late");
    c_write: cover property (write_do && w_lane0);
    c_step3: cover property (step_enter && step_index == 2'h3);
    c_badread: cover property (s_axi_rvalid &&
        s_axi_rresp == spmux_pkg::RESP_SLVERR);
    c_predict_off: cover property (step_enter ##1 !predict_enable);
endmodule

// ==== tb/spmux_cfg_tb_top.sv ====
`timescale 1ns/1ps
module spmux_cfg_tb_top;
    // ****************************************************
    // signals
    // ****************************************************
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        step_enter = 1'b0;
    logic [1:0]  step_index = 2'h0;
    logic [3:0]  step3_high_routing = 4'h0;
    logic        route_valid, predict_enable;
    logic [11:0] photodiode_route;
    logic [5:0]  mod0, mod1, mod2;
    int          error_cnt = 0;
    int          compares = 0;

    always #5 clk = ~clk;

    spmux_cfg dut (
        .clk(clk), .srst(srst),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .step_enter(step_enter), .step_index(step_index),
        .step3_high_routing(step3_high_routing),
        .route_valid(route_valid), .photodiode_route(photodiode_route),
        .modulator0_photodiodes(mod0), .modulator1_photodiodes(mod1),
        .modulator2_photodiodes(mod2), .predict_enable(predict_enable)
    );

    // ****************************************************
    // helpers
    // ****************************************************
    task automatic tally_and_finish();
        $display("compares=%0d errors=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic hang(input string what);
        error_cnt++;
        $display("[FAIL] %0t timeout in %s", $time, what);
        tally_and_finish();
    endtask

    // address and data offered together, each released once taken
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        bit done;
        done = 0;
        @(posedge clk);
        awaddr <= a; wdata <= {24'h0, d}; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                chk({30'h0, bresp}, {30'h0, er}, "bresp");
                bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) hang("write");
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [7:0] ed,
                          input logic [1:0] er);
        bit done;
        done = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                chk(rdata, {24'h0, ed}, "rdata");
                chk({30'h0, rresp}, {30'h0, er}, "rresp");
                rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) hang("read");
    endtask

    function automatic logic [5:0] mask_of(input logic [11:0] r,
                                           input logic [1:0] c);
        logic [5:0] m;
        for (int p = 0; p < 6; p++) m[p] = (r[2*p +: 2] == c);
        return m;
    endfunction

    // pulse step entry, then compare outputs once the next edge landed
    task automatic step_chk(input logic [1:0] idx, input logic [11:0] er,
                            input logic ep);
        logic v;
        v = idx[1];
        @(posedge clk);
        step_enter <= 1'b1; step_index <= idx;
        @(posedge clk);
        step_enter <= 1'b0;
        #1;
        chk({31'h0, route_valid}, {31'h0, v}, "route_valid");
        chk({20'h0, photodiode_route}, {20'h0, v ? er : 12'h000}, "route");
        chk({26'h0, mod0}, {26'h0, v ? mask_of(er, 2'h1) : 6'h0}, "mod0");
        chk({26'h0, mod1}, {26'h0, v ? mask_of(er, 2'h2) : 6'h0}, "mod1");
        chk({26'h0, mod2}, {26'h0, v ? mask_of(er, 2'h3) : 6'h0}, "mod2");
        chk({31'h0, predict_enable}, {31'h0, ep}, "predict");
    endtask

    // ****************************************************
    // tests
    // ****************************************************
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        // reset values straight from the field tables, not the package
        axi_rd(spmux_pkg::ADDR_STEP2_LOW, 8'h07, 2'h0);
        axi_rd(spmux_pkg::ADDR_STEP2_HIGH, 8'hf8, 2'h0);
        axi_rd(spmux_pkg::ADDR_STEP3_LOW, 8'h24, 2'h0);
        step_chk(2'h0, 12'h000, 1'b1);
        step_chk(2'h2, 12'h807, 1'b1);
        $display("test reset_values done");
        for (int i = 0; i < 3; i++) begin
            logic [7:0] d;
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'h5a;
            axi_wr(spmux_pkg::ADDR_STEP2_LOW, d, 4'h1, 2'h0);
            axi_wr(spmux_pkg::ADDR_STEP2_HIGH, ~d, 4'h1, 2'h0);
            axi_wr(spmux_pkg::ADDR_STEP3_LOW, d ^ 8'h3c, 4'h1, 2'h0);
            axi_rd(spmux_pkg::ADDR_STEP2_LOW, d, 2'h0);
            axi_rd(spmux_pkg::ADDR_STEP2_HIGH, ~d, 2'h0);
            axi_rd(spmux_pkg::ADDR_STEP3_LOW, d ^ 8'h3c, 2'h0);
        end
        $display("test read_back done");
        // lane 0 not strobed: nothing written; unmapped place refused
        axi_wr(spmux_pkg::ADDR_STEP2_LOW, 8'h11, 4'he, 2'h0);
        axi_rd(spmux_pkg::ADDR_STEP2_LOW, 8'h5a, 2'h0);
        axi_wr(12'h38c, 8'h77, 4'h1, 2'h2);
        axi_rd(12'h38c, 8'h00, 2'h2);
        $display("test refusals done");
        // every routing code on some photodiode; pattern 0101
        axi_wr(spmux_pkg::ADDR_STEP2_LOW, 8'he4, 4'h1, 2'h0);
        axi_wr(spmux_pkg::ADDR_STEP2_HIGH, 8'h5d, 4'h1, 2'h0);
        axi_wr(spmux_pkg::ADDR_STEP3_LOW, 8'h1b, 4'h1, 2'h0);
        step3_high_routing <= 4'h6;
        step_chk(2'h0, 12'h000, 1'b1);
        step_chk(2'h1, 12'h000, 1'b0);
        step_chk(2'h3, 12'h61b, 1'b0);
        step_chk(2'h2, 12'hde4, 1'b1);
        // change during a step waits for the next entry
        axi_wr(spmux_pkg::ADDR_STEP2_HIGH, 8'ha2, 4'h1, 2'h0);
        chk({20'h0, photodiode_route}, 32'hde4, "held route");
        step_chk(2'h2, 12'h2e4, 1'b0);
        step_chk(2'h3, 12'h61b, 1'b1);
        $display("test step_routing done");
        tally_and_finish();
    end
endmodule
